// ### rtl/pgc_top.sv
`default_nettype none
module pgc_top #(
    parameter int LINE_PIX = pgc_pkg::LINE_PIX_DEF,
    // Identity values are arbitrary
    parameter logic [15:0] TYPE_ID = 16'h0001,
    parameter logic [15:0] VERSION_ID = 16'h0001,
    parameter logic [15:0] SERIAL_NO = 16'h0001,
    localparam int IDX_W = $clog2(LINE_PIX)
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic rx,
    output logic tx,
    input wire logic baud_fast,
    input wire logic mode_8bit,
    input wire logic [pgc_pkg::PIX_W-1:0] pix_in,
    input wire logic pix_valid,
    input wire logic line_start,
    output logic [IDX_W-1:0] pix_addr,
    input wire logic [pgc_pkg::PIX_W-1:0] fac_black,
    input wire logic [pgc_pkg::PIX_W-1:0] fac_white,
    output logic [pgc_pkg::PIX_W-1:0] pix_out,
    output logic pix_out_valid,
    output logic [2:0] analog_gain_code,
    output logic [3:0] analog_gain_factor,
    output logic [7:0] digital_gain,
    output logic [2:0] corr_mode,
    output logic [9:0] corr_target,
    output logic test_pattern_on,
    output logic cmd_busy
);
    import pgc_pkg::*;

    if (LINE_PIX % (RAMP8_REPS * 4) != 0 || LINE_PIX < RAMP10_TOP) begin : g_chk
        $error("LINE_PIX must be a multiple of 96 and at least 1024");
    end

    typedef enum logic [2:0] {
        RS_IDLE = 3'b000, RS_GT = 3'b001, RS_LBL = 3'b011, RS_SEP = 3'b010,
        RS_NUM = 3'b110, RS_CR = 3'b111
    } pgc_rstate_t;

    // ----------------------------------------
    // Serial receive and transmit
    // ----------------------------------------
    logic [15:0] bit_cyc;
    logic rx_busy, rx_strobe;
    logic [15:0] rx_cnt, tx_cnt;
    logic [3:0] rx_bit, tx_bit;
    logic [7:0] rx_sh, rx_byte;
    logic tx_busy, tx_go;
    logic [9:0] tx_sh;
    logic [7:0] tx_char;

    assign bit_cyc = baud_fast ? BIT_FAST : BIT_SLOW;
    assign tx = tx_sh[0];

    always_ff @(posedge clk) begin
        rx_strobe <= 1'b0;
        if (reset) begin
            rx_busy <= 1'b0;
            rx_cnt <= 16'h0000;
            rx_bit <= 4'h0;
            rx_sh <= 8'h00;
            rx_byte <= 8'h00;
        end else if (!rx_busy) begin
            if (!rx) begin
                rx_busy <= 1'b1;
                rx_cnt <= bit_cyc >> 1;
                rx_bit <= 4'h0;
            end
        end else if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
        end else begin
            rx_cnt <= bit_cyc - 16'h0001;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0) begin
                // A start bit gone by mid-bit was a glitch
                if (rx) begin
                    rx_busy <= 1'b0;
                end
            end else if (rx_bit == 4'h9) begin
                rx_busy <= 1'b0;
                if (rx) begin
                    rx_strobe <= 1'b1;
                    rx_byte <= rx_sh;
                end
            end else begin
                rx_sh <= {rx, rx_sh[7:1]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_busy <= 1'b0;
            tx_sh <= 10'h3FF;
            tx_cnt <= 16'h0000;
            tx_bit <= 4'h0;
        end else if (!tx_busy) begin
            if (tx_go) begin
                tx_sh <= {1'b1, tx_char, 1'b0};
                tx_busy <= 1'b1;
                tx_cnt <= bit_cyc - 16'h0001;
                tx_bit <= 4'h0;
            end
        end else if (tx_cnt != 16'h0000) begin
            tx_cnt <= tx_cnt - 16'h0001;
        end else begin
            tx_sh <= {1'b1, tx_sh[9:1]};
            tx_cnt <= bit_cyc - 16'h0001;
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == 4'h9) begin
                tx_busy <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Command parsing and settings
    // ----------------------------------------
    logic [31:0] name;
    logic [15:0] arg0, arg1;
    logic [1:0] field, has_arg;
    logic is_cr, exec, cmd_ok;
    pgc_label_t cmd_lbl;
    logic [3:0] ch_digit;
    logic cap_arm, cap_run, cap_white, cap_done, start_reply;
    pgc_rstate_t rs;
    pgc_label_t rep_cmd;

    assign is_cr = rx_strobe && rx_byte == CH_CR;
    assign cmd_busy = rs != RS_IDLE || cap_arm || cap_run || tx_busy;
    // Commands during a reply or capture are dropped
    assign exec = is_cr && !cmd_busy;
    assign cmd_lbl = match_label(name);
    assign ch_digit = 4'(rx_byte - CH_0);

    always_comb begin
        case (cmd_lbl)
            L_GAX: cmd_ok = has_arg[0] && arg0 < 16'h0008;
            L_GDX: cmd_ok = has_arg[0] && arg0 < 16'h0100;
            L_FFCM: cmd_ok = has_arg[0] && (arg0 < 16'h0003 || arg0 == 16'h0004
                || arg0 == 16'h0005) && (!has_arg[1] || arg1 < 16'h0400);
            L_FFCT: cmd_ok = has_arg[0] && arg0 < 16'h0400;
            L_TPN: cmd_ok = has_arg[0] && arg0 < 16'h0002;
            L_BLK, L_WHT, L_STA: cmd_ok = 1'b1;
            default: cmd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset || is_cr) begin
            name <= 32'h0;
            arg0 <= 16'h0000;
            arg1 <= 16'h0000;
            field <= 2'h0;
            has_arg <= 2'h0;
        end else if (rx_strobe) begin
            if (rx_byte == CH_SP) begin
                field <= (field == 2'h2) ? field : field + 2'h1;
            end else if (field == 2'h0) begin
                name <= {name[23:0], rx_byte};
            end else if (ch_digit < 4'hA && rx_byte >= CH_0) begin
                if (field == 2'h1) begin
                    arg0 <= 16'(arg0 * 16'd10 + 16'(ch_digit));
                    has_arg[0] <= 1'b1;
                end else begin
                    arg1 <= 16'(arg1 * 16'd10 + 16'(ch_digit));
                    has_arg[1] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            analog_gain_code <= 3'h0;
            digital_gain <= 8'h00;
            corr_mode <= MODE_RST;
            corr_target <= TARGET_RST;
            test_pattern_on <= 1'b0;
        end else if (exec && cmd_ok) begin
            case (cmd_lbl)
                L_GAX: analog_gain_code <= arg0[2:0];
                L_GDX: digital_gain <= arg0[7:0];
                L_FFCM: begin
                    corr_mode <= arg0[2:0];
                    if (has_arg[1]) begin
                        corr_target <= arg1[9:0];
                    end
                end
                L_FFCT: corr_target <= arg0[9:0];
                L_TPN: test_pattern_on <= arg0[0];
                default: ;
            endcase
        end
    end

    assign analog_gain_factor = gain_factor(analog_gain_code);

    // ----------------------------------------
    // Pixel path and reference capture
    // ----------------------------------------
    logic [IDX_W-1:0] idx, cnt, idx_d;
    logic [9:0] user_black [LINE_PIX];
    logic [9:0] user_white [LINE_PIX];
    logic cap_we;
    pgc_corr_if c ();

    assign idx = line_start ? '0 : cnt;
    assign pix_addr = idx;
    assign cap_we = pix_valid && (cap_run || (cap_arm && line_start));
    assign cap_done = cap_we && idx == IDX_W'(LINE_PIX - 1);

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt <= '0;
        end else if (pix_valid) begin
            cnt <= (idx == IDX_W'(LINE_PIX - 1)) ? '0 : idx + IDX_W'(1);
        end
    end

    // Raw input is captured so a reference never feeds on itself
    always_ff @(posedge clk) begin
        if (cap_we && !cap_white) begin
            user_black[idx] <= pix_in;
        end
        if (cap_we && cap_white) begin
            user_white[idx] <= pix_in;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cap_arm <= 1'b0;
            cap_run <= 1'b0;
            cap_white <= 1'b0;
        end else if (exec && cmd_ok && (cmd_lbl == L_BLK || cmd_lbl == L_WHT)) begin
            cap_arm <= 1'b1;
            cap_white <= cmd_lbl == L_WHT;
        end else if (cap_done) begin
            cap_arm <= 1'b0;
            cap_run <= 1'b0;
        end else if (cap_we) begin
            cap_arm <= 1'b0;
            cap_run <= 1'b1;
        end
    end

    assign c.valid_in = pix_valid;
    assign c.vin = pix_in;
    assign c.bypass = corr_mode == 3'h0 || corr_mode == 3'h3;
    assign c.blk = corr_mode[2] ? user_black[idx] : fac_black;
    assign c.wht = (corr_mode == 3'h2 || corr_mode == 3'h5) ? user_white[idx] : fac_white;
    assign c.target = corr_target;
    assign c.dgain = digital_gain;

    pgc_corr u_corr (
        .clk(clk),
        .reset(reset),
        .c(c)
    );

    function automatic logic [9:0] ramp(input logic [IDX_W-1:0] i, input logic m8);
        int seg, top;
        seg = m8 ? LINE_PIX / RAMP8_REPS : LINE_PIX / RAMP10_REPS;
        top = m8 ? RAMP8_TOP : RAMP10_TOP;
        return 10'((int'(i) % seg) * top / seg);
    endfunction

    always_ff @(posedge clk) begin
        if (reset) begin
            idx_d <= '0;
            pix_out <= 10'h000;
            pix_out_valid <= 1'b0;
        end else begin
            idx_d <= idx;
            pix_out_valid <= c.valid_out;
            if (c.valid_out) begin
                pix_out <= test_pattern_on ? ramp(idx_d, mode_8bit) : c.vout;
            end
        end
    end

    // ----------------------------------------
    // Reply generation
    // ----------------------------------------
    logic [3:0] rep_line;
    logic [2:0] pos, dig;
    logic started, emit, adv;
    pgc_label_t cur;
    logic [15:0] val;
    logic [3:0] d;
    logic [47:0] txt;

    assign start_reply = exec ? !(cmd_ok && (cmd_lbl == L_BLK || cmd_lbl == L_WHT))
        : cap_done;

    always_comb begin
        if (rep_cmd == L_NG) begin
            cur = L_NG;
        end else if (rep_line == 4'h0) begin
            cur = L_OK;
        end else if (rep_cmd == L_STA && rep_line < 4'h9) begin
            cur = pgc_label_t'(rep_line + 4'h1);
        end else begin
            cur = rep_cmd;
        end
        case (cur)
            L_TYPE: val = TYPE_ID;
            L_VER: val = VERSION_ID;
            L_SER: val = SERIAL_NO;
            L_GAX: val = 16'(analog_gain_code);
            L_GDX: val = 16'(digital_gain);
            L_FFCM: val = 16'(corr_mode);
            L_FFCT: val = 16'(corr_target);
            L_TPN: val = 16'(test_pattern_on);
            default: val = 16'h0000;
        endcase
        txt = label_text(cur);
        d = dec_digit(val, dig);
        emit = 1'b1;
        case (rs)
            RS_GT: tx_char = CH_GT;
            RS_LBL: begin
                tx_char = txt[8*pos +: 8];
                emit = tx_char != 8'h00;
            end
            RS_SEP: tx_char = (cur <= L_SER) ? CH_EQ : CH_SP;
            RS_NUM: begin
                tx_char = CH_0 + 8'(d);
                emit = started || d != 4'h0 || dig == 3'h0;
            end
            RS_CR: tx_char = CH_CR;
            default: begin
                tx_char = 8'h00;
                emit = 1'b0;
            end
        endcase
    end

    assign tx_go = rs != RS_IDLE && !tx_busy && emit;
    assign adv = rs != RS_IDLE && !tx_busy;

    always_ff @(posedge clk) begin
        if (reset) begin
            rs <= RS_IDLE;
            rep_cmd <= L_OK;
            rep_line <= 4'h0;
            pos <= 3'h0;
            dig <= 3'h0;
            started <= 1'b0;
        end else if (start_reply) begin
            rs <= RS_GT;
            rep_line <= 4'h0;
            if (exec) begin
                rep_cmd <= cmd_ok ? cmd_lbl : L_NG;
            end
        end else if (adv) begin
            case (rs)
                RS_GT: begin
                    rs <= RS_LBL;
                    pos <= 3'h5;
                end
                RS_LBL: begin
                    pos <= pos - 3'h1;
                    if (pos == 3'h0) begin
                        rs <= (cur != L_OK && cur != rep_cmd) ? RS_SEP : RS_CR;
                    end
                end
                RS_SEP: begin
                    rs <= RS_NUM;
                    dig <= 3'h4;
                    started <= 1'b0;
                end
                RS_NUM: begin
                    started <= started || emit;
                    dig <= dig - 3'h1;
                    if (dig == 3'h0) begin
                        rs <= RS_CR;
                    end
                end
                RS_CR: begin
                    rep_line <= rep_line + 4'h1;
                    rs <= RS_GT;
                    if (rep_cmd == L_NG || (rep_cmd == L_STA && rep_line == 4'h9)
                            || (rep_cmd != L_STA && rep_line == 4'h1)) begin
                        rs <= RS_IDLE;
                    end
                end
                default: rs <= RS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### rtl/pgc_pkg.sv
// Operation
// - Analog gain has eight steps up to x10; digital gain is separate.
// - Analog gain codes 0..7 give factors 1,2,3,4,5,6,8,10.
// - Analog gain command with a code selects the new analog step.
// - Digital gain command sets the digital multiplier on output pixels.
// - Corrected pixel is (in - black) * target / (white - black).
// - Correction target is a ten-bit value scaling the numerator.
// - Mode 0 none, 1 FB+FW, 2 FB+UW, 3 unused, 4 UB+FW, 5 UB+UW.
// - Correction mode is 1 after reset.
// - Black acquisition command captures one line as user black reference.
// - White acquisition ends with CR; capture, then reply OK and echo; the code replays the prior command's reply.
// - Mode 2 with a level argument also loads the target level.
// - Default target level is 800.
// - Eight-bit test pattern: ramp 0..255 repeated 24 times per line.
// - Ten-bit test pattern: ramp 0..1023 repeated 4 times per line.
// - Status command replies OK, type, version, serial, settings, echo.
// - Serial link 9600 or 115200 baud, 8 data, no parity, 1 stop.
`default_nettype none
package pgc_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_SLOW = 9600;
    localparam int BAUD_FAST = 115200;
    localparam logic [15:0] BIT_SLOW = 16'(CLK_HZ / BAUD_SLOW);
    localparam logic [15:0] BIT_FAST = 16'(CLK_HZ / BAUD_FAST);
    // ----------------------------------------
    // Datapath and defaults
    // ----------------------------------------
    localparam int PIX_W = 10;
    localparam logic [9:0] PIX_MAX = 10'h3FF;
    localparam int RAMP8_REPS = 24;
    localparam int RAMP10_REPS = 4;
    localparam int RAMP8_TOP = 256;
    localparam int RAMP10_TOP = 1024;
    localparam int LINE_PIX_DEF = RAMP8_REPS * RAMP8_TOP;
    localparam logic [2:0] MODE_RST = 3'h1;
    localparam logic [9:0] TARGET_RST = 10'h320;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_GT = 8'h3E;
    localparam logic [7:0] CH_EQ = 8'h3D;
    localparam logic [7:0] CH_0 = 8'h30;

    typedef enum logic [3:0] {
        L_OK, L_NG, L_TYPE, L_VER, L_SER, L_GAX, L_GDX, L_FFCM, L_FFCT, L_TPN,
        L_BLK, L_WHT, L_STA
    } pgc_label_t;

    function automatic logic [47:0] label_text(input pgc_label_t l);
        case (l)
            L_OK: return 48'("OK");
            L_NG: return 48'("NG");
            L_TYPE: return 48'("Type");
            L_VER: return 48'("Ver.");
            L_SER: return 48'("Serial");
            L_GAX: return 48'("gax");
            L_GDX: return 48'("gdx");
            L_FFCM: return 48'("ffcm");
            L_FFCT: return 48'("ffct");
            L_TPN: return 48'("tpn");
            L_BLK: return 48'("blk");
            L_WHT: return 48'("wht");
            default: return 48'("sta");
        endcase
    endfunction

    // Only lower-case command names can match
    function automatic pgc_label_t match_label(input logic [31:0] name);
        pgc_label_t r;
        r = L_NG;
        for (int i = int'(L_GAX); i <= int'(L_STA); i++) begin
            if (label_text(pgc_label_t'(i)) == {16'h0000, name}) begin
                r = pgc_label_t'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] gain_factor(input logic [2:0] code);
        case (code)
            3'h6: return 4'h8;
            3'h7: return 4'hA;
            default: return 4'({1'b0, code} + 4'h1);
        endcase
    endfunction

    function automatic logic [3:0] dec_digit(input logic [15:0] v, input logic [2:0] k);
        int p;
        p = 1;
        for (int i = 0; i < 5; i++) begin
            if (i < int'(k)) begin
                p = p * 10;
            end
        end
        return 4'((int'(v) / p) % 10);
    endfunction
endpackage
`default_nettype wire

// ### rtl/pgc_corr_if.sv
`default_nettype none
interface pgc_corr_if;
    logic valid_in;
    logic bypass;
    logic [9:0] vin;
    logic [9:0] blk;
    logic [9:0] wht;
    logic [9:0] target;
    logic [7:0] dgain;
    logic valid_out;
    logic [9:0] vout;
    modport src (output valid_in, bypass, vin, blk, wht, target, dgain,
        input valid_out, vout);
    modport core (input valid_in, bypass, vin, blk, wht, target, dgain,
        output valid_out, vout);
endinterface
`default_nettype wire

// ### rtl/pgc_corr.sv
`default_nettype none
module pgc_corr (
    input wire logic clk,
    input wire logic reset,
    pgc_corr_if.core c
);
    import pgc_pkg::*;

    // Digital gain x(1 + code/256)
    function automatic logic [9:0] correct(input logic [9:0] vin, input logic [9:0] blk,
            input logic [9:0] wht, input logic [9:0] tgt, input logic [7:0] dg,
            input logic byp);
        logic [31:0] num;
        logic [31:0] den;
        logic [31:0] q;
        num = (vin > blk) ? 32'(vin - blk) : 32'h0;
        den = (wht > blk) ? 32'(wht - blk) : 32'h0;
        if (byp) begin
            q = 32'(vin);
        end else if (den == 32'h0) begin
            q = (num != 32'h0) ? 32'(PIX_MAX) : 32'h0;
        end else begin
            q = num * 32'(tgt) / den;
        end
        q = (q * (32'h100 + 32'(dg))) >> 8;
        return (q > 32'(PIX_MAX)) ? PIX_MAX : q[9:0];
    endfunction

    always_ff @(posedge clk) begin
        if (reset) begin
            c.valid_out <= 1'b0;
            c.vout <= 10'h000;
        end else begin
            c.valid_out <= c.valid_in;
            if (c.valid_in) begin
                c.vout <= correct(c.vin, c.blk, c.wht, c.target, c.dgain, c.bypass);
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/pgc_host.sv
`default_nettype none
module pgc_host #(
    parameter int BIT = 173
) (
    input wire logic clk,
    input wire logic tx,
    output logic rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    initial rx = 1'b1;
    // ------
    // Command side
    // ------
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask
    task automatic send_cmd(input string s);
        @(posedge clk);
        for (int i = 0; i < s.len(); i++) begin
            send_byte(8'(s[i]));
        end
        send_byte(8'h0D);
    endtask
    // ------
    // Reply side, mid-bit
    // ------
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge tx);
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk);
                b[i] = tx;
            end
            repeat (BIT) @(posedge clk);
            if (tx) got.push_back(b);
        end
    end
endmodule
`default_nettype wire

// ### sim/pgc_top_props.sv
`default_nettype none
module pgc_top_props #(
    parameter int LINE_PIX = 1536,
    localparam int IDX_W = $clog2(LINE_PIX)
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tx,
    input wire logic mode_8bit,
    input wire logic [9:0] pix_in,
    input wire logic pix_valid,
    input wire logic line_start,
    input wire logic [IDX_W-1:0] pix_addr,
    input wire logic [9:0] fac_black,
    input wire logic [9:0] pix_out,
    input wire logic pix_out_valid,
    input wire logic [2:0] analog_gain_code,
    input wire logic [3:0] analog_gain_factor,
    input wire logic [7:0] digital_gain,
    input wire logic [2:0] corr_mode,
    input wire logic [9:0] corr_target,
    input wire logic test_pattern_on,
    input wire logic cmd_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SEG8 = LINE_PIX / 24;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_live;
        pix_valid && !test_pattern_on;
    endsequence
    sequence s_out_after;
        ##2 pix_out_valid;
    endsequence
    a_valid_lag: assert property (pix_valid |-> s_out_after)
        else $error("no result");
    a_valid_none: assert property (!pix_valid |-> ##2 !pix_out_valid)
        else $error("stray result");
    a_reset_state: assert property ($fell(reset) |-> corr_mode == 3'h1 &&
        corr_target == 10'h320 && analog_gain_code == 3'h0 && !test_pattern_on)
        else $error("bad reset");
    a_gain_map: assert property (analog_gain_factor == (analog_gain_code == 3'h7 ? 4'hA
        : analog_gain_code == 3'h6 ? 4'h8 : 4'(analog_gain_code) + 4'h1))
        else $error("bad factor");
    a_mode_legal: assert property (corr_mode != 3'h3 && corr_mode <= 3'h5)
        else $error("bad mode");
    a_black_floor: assert property (s_live ##0 (corr_mode inside {3'h1, 3'h2})
        ##0 (pix_in <= fac_black) |-> ##2 pix_out == 10'h000)
        else $error("not zero");
    a_bypass_same: assert property (s_live ##0 corr_mode == 3'h0
        ##0 digital_gain == 8'h00 |-> ##2 pix_out == $past(pix_in, 2))
        else $error("bypass pixel altered");
    a_ramp_origin: assert property (pix_valid && line_start && test_pattern_on
        |-> ##2 pix_out == 10'h000)
        else $error("ramp origin");
    a_ramp_step: assert property (pix_valid && $past(pix_valid) && test_pattern_on
        && mode_8bit && int'(pix_addr) % SEG8 != 0
        |-> ##2 pix_out - $past(pix_out) == 10'(256 / SEG8))
        else $error("ramp step");
    a_idle_high: assert property (!cmd_busy |-> tx)
        else $error("tx not idle");
    a_start_held: assert property ($fell(tx) |-> cmd_busy ##1 !tx [*8])
        else $error("short start");
endmodule
bind pgc_top pgc_top_props #(.LINE_PIX(LINE_PIX)) i_props (
    .clk, .reset, .tx, .mode_8bit, .pix_in, .pix_valid, .line_start, .pix_addr,
    .fac_black, .pix_out, .pix_out_valid, .analog_gain_code, .analog_gain_factor,
    .digital_gain, .corr_mode, .corr_target, .test_pattern_on, .cmd_busy
);
`default_nettype wire

// ### sim/test_pixel_gain_correction_testgen.sv
`default_nettype none
module test_pixel_gain_correction_testgen;
    timeunit 1ns;
    timeprecision 1ns;
    import pgc_pkg::*;
    localparam int LP = 1536;
    localparam int BIT = int'(BIT_FAST);
    localparam int LIMIT = 99000;
    logic clk, reset, rx, tx, mode_8bit, pix_valid, line_start, pix_out_valid;
    logic test_pattern_on, cmd_busy;
    logic [9:0] pix_in, fac_black, fac_white, pix_out, corr_target;
    logic [10:0] pix_addr;
    logic [2:0] analog_gain_code, corr_mode;
    logic [3:0] analog_gain_factor;
    logic [7:0] digital_gain;
    logic [9:0] outq[$];
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    pgc_top #(.LINE_PIX(LP)) i_dut (
        .clk, .reset, .rx, .tx, .baud_fast(1'b1), .mode_8bit, .pix_in, .pix_valid,
        .line_start, .pix_addr, .fac_black, .fac_white, .pix_out, .pix_out_valid,
        .analog_gain_code, .analog_gain_factor, .digital_gain, .corr_mode, .corr_target,
        .test_pattern_on, .cmd_busy
    );
    pgc_host #(.BIT(BIT)) i_host (.clk, .tx, .rx);
    // ------
    // Factory references
    // ------
    function automatic logic [9:0] ref_b(input int k);
        return 10'(20 + k % 50);
    endfunction
    function automatic logic [9:0] ref_w(input int k);
        return (k % 97 == 0) ? ref_b(k) : 10'(700 + k % 100);
    endfunction
    assign fac_black = ref_b(int'(pix_addr));
    assign fac_white = ref_w(int'(pix_addr));
    function automatic int expect_pix(input int k, input int sel);
        int v, b, w;
        v = (k * 7) % 1024;
        b = int'(ref_b(k));
        w = int'(ref_w(k));
        if (sel == 1) return v;
        if (sel == 2) return (k % (LP / 24)) * 256 / (LP / 24);
        if (sel == 3) return (k % (LP / 4)) * 1024 / (LP / 4);
        if (v <= b) return 0;
        if (w <= b) return 1023;
        v = (v - b) * 800 / (w - b);
        return (v > 1023) ? 1023 : v;
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic run_line();
        outq.delete();
        for (int k = 0; k < LP; k++) begin
            @(posedge clk);
            pix_valid <= 1'b1;
            line_start <= (k == 0);
            pix_in <= 10'((k * 7) % 1024);
        end
        @(posedge clk);
        pix_valid <= 1'b0;
        line_start <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic check_line(input int sel);
        check("line length", 16'(LP), 16'(outq.size()));
        for (int k = 0; k < LP && k < outq.size(); k++) begin
            case (sel)
                0: check("corrected", 16'(expect_pix(k, 0)), 16'(outq[k]));
                1: check("bypassed", 16'(expect_pix(k, 1)), 16'(outq[k]));
                2: check("ramp 8", 16'(expect_pix(k, 2)), 16'(outq[k]));
                default: check("ramp 10", 16'(expect_pix(k, 3)), 16'(outq[k]));
            endcase
        end
    endtask
    task automatic command(input string s);
        int n = 0;
        i_host.got.delete();
        i_host.send_cmd(s);
        @(negedge clk);
        while (cmd_busy !== 1'b0 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        repeat (2 * BIT) @(negedge clk);
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_reset();
        check("corr_mode", 16'h0001, 16'(corr_mode));
        check("corr_target", 16'h0320, 16'(corr_target));
        check("gain code", 16'h0000, 16'(analog_gain_code));
        check("pattern", 16'h0000, 16'(test_pattern_on));
        run_line();
        check_line(0);
        $display("reset done");
    endtask
    task automatic t_gain();
        string s = ">OK\015>gax\015";
        command("gax 7");
        check("gain code", 16'h0007, 16'(analog_gain_code));
        check("gain factor", 16'h000A, 16'(analog_gain_factor));
        check("reply count", 16'(s.len()), 16'(i_host.got.size()));
        for (int i = 0; i < s.len() && i < i_host.got.size(); i++) begin
            check("reply byte", 16'(s[i]), 16'(i_host.got[i]));
        end
        $display("gain done");
    endtask
    task automatic t_bypass();
        command("ffcm 0");
        check("corr_mode", 16'h0000, 16'(corr_mode));
        run_line();
        check_line(1);
        $display("bypass done");
    endtask
    task automatic t_pattern();
        command("tpn 1");
        check("pattern", 16'h0001, 16'(test_pattern_on));
        run_line();
        check_line(2);
        mode_8bit <= 1'b0;
        run_line();
        check_line(3);
        $display("pattern done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pix_out_valid === 1'b1) outq.push_back(pix_out);
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        reset = 1'b1;
        mode_8bit = 1'b1;
        pix_valid = 1'b0;
        line_start = 1'b0;
        pix_in = 10'h000;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        t_reset();
        t_gain();
        t_bypass();
        t_pattern();
        wrap_up();
    end
endmodule
`default_nettype wire
